/* File: common/adc_burst_pkg.sv */
// Constants, types and register map for the burst accumulator control block
package adc_burst_pkg;

  // Register pages and addresses on the core register bus
  localparam logic [7:0] PAGE_MAIN = 8'h00;
  localparam logic [7:0] PAGE_CFG = 8'h0f;
  localparam logic [7:0] ADDR_ACC_CFG = 8'hba;
  localparam logic [7:0] ADDR_PWR_TIME = 8'hba;
  localparam logic [7:0] ADDR_TRACK_TIME = 8'hbd;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_RES_LOW = 8'hbd;

  // Reset values
  localparam logic [7:0] ACC_CFG_RST = 8'h00;
  localparam logic [7:0] PWR_TIME_RST = 8'h0f;
  localparam logic [7:0] TRACK_TIME_RST = 8'h1e;
  localparam logic [15:0] ACCUM_RST = 16'h0000;

  // Field positions
  localparam int TWELVE_BIT_POS = 7;
  localparam int ACCUM_ON_POS = 6;
  localparam int SJST_MSB = 5;
  localparam int SJST_LSB = 3;
  localparam int RPT_MSB = 2;
  localparam int RPT_LSB = 0;
  localparam int LOW_POWER_POS = 7;
  localparam int PWR_FIELD_MSB = 3;
  localparam int TK_FIELD_MSB = 5;

  // Shift and justify codes
  localparam logic [2:0] SJST_SHIFT3 = 3'h3;
  localparam logic [2:0] SJST_LEFT = 3'h4;
  localparam int LEFT_SHIFT_12BIT = 4;
  localparam int LEFT_SHIFT_10BIT = 6;

  // Repeat count codes
  localparam logic [2:0] RPT_CODE_MAX = 3'h5;

  // Timing, clock is 40 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int POWERUP_STEP_NS = 400;
  localparam int TRACK_STEP_NS = 50;
  localparam int POWERUP_STEP_CYC = (POWERUP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRACK_STEP_CYC = (TRACK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRACK_BASE = 64;
  localparam logic [8:0] DELAYED_TRACK_SAR_CYC = 9'h003;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } conv_result_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_POWERUP,
    ST_TRACK,
    ST_DELAY_TRACK,
    ST_CONVERT
  } seq_state_e;

endpackage

/* File: rtl/adc_delay_timer.sv */
// Loadable down-counter that pulses once when its count of ticks expires
`timescale 1ns/10ps
`default_nettype none
module adc_delay_timer (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [8:0] load_val_in,
  input wire logic tick_in,
  output logic done_out
);

  logic [8:0] count_q;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_q <= 9'h000;
    end else if (load_in) begin
      count_q <= load_val_in;
    end else if (tick_in && count_q != 9'h000) begin
      count_q <= count_q - 9'h001;
    end
  end

  // Pulse lands in the cycle after the last tick is counted
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= !load_in && tick_in && count_q == 9'h001;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/adc_result_format.sv */
// Shift and justify formatting of the accumulator for register reads
`timescale 1ns/10ps
`default_nettype none
module adc_result_format
  import adc_burst_pkg::*;
(
  input wire logic [15:0] accum_in,
  input wire logic [2:0] shift_justify_sel_in,
  input wire logic twelve_bit_mode_on_in,
  output logic [15:0] formatted_out
);

  always_comb begin
    if (shift_justify_sel_in <= SJST_SHIFT3) begin
      formatted_out = accum_in >> shift_justify_sel_in;
    end else if (shift_justify_sel_in == SJST_LEFT) begin
      formatted_out = twelve_bit_mode_on_in ? (accum_in << LEFT_SHIFT_12BIT)
                                           : (accum_in << LEFT_SHIFT_10BIT);
    end else begin
      // Reserved codes show the raw sum rather than garbage
      formatted_out = accum_in;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/adc_burst_ctrl.sv */
// Burst, accumulate, power-up and track sequencing for the converter
//
// What this block does
// - Accumulator config bit 7 turns twelve-bit mode on when one, off when zero.
// - Without burst, result holds latest sample, or running sum when accumulate is on.
// - Accumulate-enable is write-only; its bit always reads back zero.
// - Bits 5:3 format reads: 0-3 right shift, 4 left justify, rest reserved.
// - Bits 2:0 pick 1, 4, 8, 16, 32 or 64 burst conversions summed.
// - Power-up register bit 7 enables converter low-power mode.
// - Power-up register bits 6:4 read zero and ignore writes.
// - Without burst, powered state follows converter-enable only, no power-up delay.
// - Burst with converter enabled stays powered; in normal track it converts at once on start.
// - Burst with converter disabled powers down after burst, waits power-up delay next.
// - Power-up delay is field bits 3:0 plus one, times 400 ns.
// - Track delay between burst conversions is 64 minus bits 5:0, times 50 ns.
// - Track register bits 7:6 read zero; software writes zero there.
// - Delayed track mode adds three converter-clock cycles before each conversion.
// - No burst track delay before a burst's first conversion.
// - Normal track converts at once on start; delayed track waits three converter clocks.
`timescale 1ns/10ps
`default_nettype none
module adc_burst_ctrl (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire adc_burst_pkg::sfr_req_s sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_rvalid_out,
  input wire logic burst_mode_on_in,
  input wire logic converter_on_in,
  input wire logic track_mode_sel_in,
  input wire logic start_conv_in,
  input wire logic sar_clk_en_in,
  input wire adc_burst_pkg::conv_result_s conv_result_in,
  output logic conv_start_out,
  output logic powered_out,
  output logic low_power_on_out,
  output logic twelve_bit_mode_on_out,
  output logic busy_out
);
  import adc_burst_pkg::*;

  // Register state
  logic twelve_bit_mode_on_q;
  logic accumulate_on_q;
  logic [2:0] shift_justify_sel_q;
  logic [2:0] repeat_count_sel_q;
  logic low_power_on_q;
  logic [3:0] powerup_delay_field_q;
  logic [5:0] burst_track_field_q;
  logic [15:0] accum_q;

  // Sequencer state
  seq_state_e state_q;
  seq_state_e state_d;
  logic [6:0] conv_count_q;
  logic [6:0] conv_count_d;
  logic cycle_load;
  logic [8:0] cycle_load_val;
  logic cycle_done;
  logic sar_load;
  logic sar_done;
  logic start_d;
  logic conv_event;
  logic [6:0] repeat_target;
  logic [15:0] formatted;
  logic [8:0] powerup_cycles;
  logic [8:0] track_cycles;
  logic [15:0] sample_ext;

  // Register bus decode
  // Page and address must both match, since the two pages reuse addresses
  logic wr_acc_cfg;
  logic wr_pwr_time;
  logic wr_track_time;
  logic wr_res_high;
  logic wr_res_low;

  assign wr_acc_cfg = sfr_req_in.wr && sfr_req_in.page == PAGE_MAIN
                      && sfr_req_in.addr == ADDR_ACC_CFG;
  assign wr_res_high = sfr_req_in.wr && sfr_req_in.page == PAGE_MAIN
                       && sfr_req_in.addr == ADDR_RES_HIGH;
  assign wr_res_low = sfr_req_in.wr && sfr_req_in.page == PAGE_MAIN
                      && sfr_req_in.addr == ADDR_RES_LOW;
  assign wr_pwr_time = sfr_req_in.wr && sfr_req_in.page == PAGE_CFG
                       && sfr_req_in.addr == ADDR_PWR_TIME;
  assign wr_track_time = sfr_req_in.wr && sfr_req_in.page == PAGE_CFG
                         && sfr_req_in.addr == ADDR_TRACK_TIME;

  // Delay counts in core clock cycles
  // Steps round up to whole core cycles, so no delay comes out short
  assign powerup_cycles = 9'((5'(powerup_delay_field_q) + 5'h01)
                          * POWERUP_STEP_CYC);
  assign track_cycles = 9'((7'(TRACK_BASE) - 7'(burst_track_field_q))
                        * TRACK_STEP_CYC);

  // Conversions per burst; reserved codes fall back to a single conversion
  always_comb begin
    if (repeat_count_sel_q == 3'h0 || repeat_count_sel_q > RPT_CODE_MAX) begin
      repeat_target = 7'h01;
    end else begin
      repeat_target = 7'h01 << (repeat_count_sel_q + 3'h1);
    end
  end

  // A result that arrives outside a conversion is not ours and is dropped
  assign conv_event = state_q == ST_CONVERT && conv_result_in.valid;

  // Sixty-four full-scale samples overflow 16 bits; the sum simply wraps
  assign sample_ext = {4'h0, conv_result_in.data};

  // Configuration register writes
  // Repeat and format codes are stored as written; reserved ones decode safely
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      twelve_bit_mode_on_q <= ACC_CFG_RST[TWELVE_BIT_POS];
      accumulate_on_q <= ACC_CFG_RST[ACCUM_ON_POS];
      shift_justify_sel_q <= ACC_CFG_RST[SJST_MSB:SJST_LSB];
      repeat_count_sel_q <= ACC_CFG_RST[RPT_MSB:RPT_LSB];
    end else if (wr_acc_cfg) begin
      twelve_bit_mode_on_q <= sfr_req_in.wdata[TWELVE_BIT_POS];
      accumulate_on_q <= sfr_req_in.wdata[ACCUM_ON_POS];
      shift_justify_sel_q <= sfr_req_in.wdata[SJST_MSB:SJST_LSB];
      repeat_count_sel_q <= sfr_req_in.wdata[RPT_MSB:RPT_LSB];
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_power_on_q <= PWR_TIME_RST[LOW_POWER_POS];
      powerup_delay_field_q <= PWR_TIME_RST[PWR_FIELD_MSB:0];
    end else if (wr_pwr_time) begin
      // Bits 6:4 are not stored at all
      low_power_on_q <= sfr_req_in.wdata[LOW_POWER_POS];
      powerup_delay_field_q <= sfr_req_in.wdata[PWR_FIELD_MSB:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      burst_track_field_q <= TRACK_TIME_RST[TK_FIELD_MSB:0];
    end else if (wr_track_time) begin
      // Bits 7:6 are not stored, so they can only read back zero
      burst_track_field_q <= sfr_req_in.wdata[TK_FIELD_MSB:0];
    end
  end

  // Accumulator: a finishing conversion wins over a software byte write
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      accum_q <= ACCUM_RST;
    end else if (conv_event) begin
      if (burst_mode_on_in) begin
        // First sample of a burst replaces the sum, so bursts never carry over
        accum_q <= (conv_count_q == 7'h00) ? sample_ext : accum_q + sample_ext;
      end else if (accumulate_on_q) begin
        accum_q <= accum_q + sample_ext;
      end else begin
        accum_q <= sample_ext;
      end
    end else if (wr_res_high) begin
      // Apart from reset, the sum is restarted only by these writes, a burst's first sample or a non-accumulating sample
      accum_q[15:8] <= sfr_req_in.wdata;
    end else if (wr_res_low) begin
      accum_q[7:0] <= sfr_req_in.wdata;
    end
  end

  adc_result_format u_format (
    .accum_in(accum_q),
    .shift_justify_sel_in(shift_justify_sel_q),
    .twelve_bit_mode_on_in(twelve_bit_mode_on_q),
    .formatted_out(formatted)
  );

  // Register reads answer one cycle after the read strobe
  // Format applies at read time, so a new format re-presents the same sum
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sfr_rdata_out <= 8'h00;
      sfr_rvalid_out <= 1'b0;
    end else begin
      sfr_rvalid_out <= sfr_req_in.rd;
      sfr_rdata_out <= 8'h00;
      if (sfr_req_in.rd && sfr_req_in.page == PAGE_MAIN) begin
        unique case (sfr_req_in.addr)
          ADDR_ACC_CFG: begin
            // Accumulate-enable position always reads zero
            sfr_rdata_out <= {twelve_bit_mode_on_q, 1'b0, shift_justify_sel_q,
                              repeat_count_sel_q};
          end
          ADDR_RES_HIGH: begin
            sfr_rdata_out <= formatted[15:8];
          end
          ADDR_RES_LOW: begin
            sfr_rdata_out <= formatted[7:0];
          end
          default: begin
            sfr_rdata_out <= 8'h00;
          end
        endcase
      end else if (sfr_req_in.rd && sfr_req_in.page == PAGE_CFG) begin
        unique case (sfr_req_in.addr)
          ADDR_PWR_TIME: begin
            sfr_rdata_out <= {low_power_on_q, 3'h0, powerup_delay_field_q};
          end
          ADDR_TRACK_TIME: begin
            sfr_rdata_out <= {2'h0, burst_track_field_q};
          end
          default: begin
            sfr_rdata_out <= 8'h00;
          end
        endcase
      end
    end
  end

  // Core-clock delays: power-up and burst track
  // Loaded on the edge the wait state is entered, so no separate arm state is needed
  adc_delay_timer u_cycle_timer (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .load_in(cycle_load),
    .load_val_in(cycle_load_val),
    .tick_in(1'b1),
    .done_out(cycle_done)
  );

  // Converter-clock delay for delayed track mode
  // Counts converter-clock enables, so its length in core cycles depends on phase
  adc_delay_timer u_sar_timer (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .load_in(sar_load),
    .load_val_in(DELAYED_TRACK_SAR_CYC),
    .tick_in(sar_clk_en_in),
    .done_out(sar_done)
  );

  // Sequencer next state
  // Each wait costs two cycles beyond its count: the timer's done flop and the state flop
  always_comb begin
    state_d = state_q;
    conv_count_d = conv_count_q;
    cycle_load = 1'b0;
    cycle_load_val = powerup_cycles;
    sar_load = 1'b0;
    start_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (start_conv_in) begin
          conv_count_d = 7'h00;
          // Burst off with the converter off: nothing is powered, so the start is dropped
          if (burst_mode_on_in && !converter_on_in) begin
            // Powered down between bursts, so wait out the power-up time first
            state_d = ST_POWERUP;
            cycle_load = 1'b1;
            cycle_load_val = powerup_cycles;
          end else if (converter_on_in) begin
            if (track_mode_sel_in) begin
              state_d = ST_DELAY_TRACK;
              sar_load = 1'b1;
            end else begin
              state_d = ST_CONVERT;
              start_d = 1'b1;
            end
          end
        end
      end
      ST_POWERUP, ST_TRACK: begin
        // Both waits end the same way; only the timer's load value differed
        if (cycle_done) begin
          if (track_mode_sel_in) begin
            state_d = ST_DELAY_TRACK;
            sar_load = 1'b1;
          end else begin
            state_d = ST_CONVERT;
            start_d = 1'b1;
          end
        end
      end
      ST_DELAY_TRACK: begin
        if (sar_done) begin
          state_d = ST_CONVERT;
          start_d = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (conv_result_in.valid) begin
          // Count includes this result, so the compare sees the total after it
          conv_count_d = conv_count_q + 7'h01;
          if (burst_mode_on_in && conv_count_d < repeat_target) begin
            // Track delay only sits between conversions, never before the first
            state_d = ST_TRACK;
            cycle_load = 1'b1;
            cycle_load_val = track_cycles;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State and conversion count
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      conv_count_q <= 7'h00;
    end else begin
      state_q <= state_d;
      conv_count_q <= conv_count_d;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      conv_start_out <= 1'b0;
      powered_out <= 1'b0;
      busy_out <= 1'b0;
      low_power_on_out <= 1'b0;
      twelve_bit_mode_on_out <= 1'b0;
    end else begin
      conv_start_out <= start_d;
      // Taken from state_d so busy matches the state register with no lag
      busy_out <= state_d != ST_IDLE;
      low_power_on_out <= low_power_on_q;
      twelve_bit_mode_on_out <= twelve_bit_mode_on_q;
      if (!burst_mode_on_in) begin
        powered_out <= converter_on_in;
      end else begin
        // Powered through the whole power-up wait so the input can settle
        powered_out <= converter_on_in || state_d != ST_IDLE;
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/adc_burst_ctrl_chk.sv */
// Assertion checker for the burst accumulator control block
`timescale 1ns/10ps
`default_nettype none
module adc_burst_ctrl_chk
  import adc_burst_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire adc_burst_pkg::sfr_req_s sfr_req_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_rvalid_out,
  input wire logic burst_mode_on_in,
  input wire logic converter_on_in,
  input wire logic track_mode_sel_in,
  input wire logic start_conv_in,
  input wire logic conv_start_out,
  input wire logic powered_out,
  input wire logic low_power_on_out,
  input wire logic twelve_bit_mode_on_out,
  input wire logic busy_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  logic [3:0] pwr_q;
  logic wait_q;
  logic [8:0] cnt_q;
  logic take_pwr;
  function automatic logic hit(input logic [7:0] pg, input logic [7:0] ad);
    return sfr_req_in.page == pg && sfr_req_in.addr == ad;
  endfunction
  // Only the plain power-up path is timed; delayed track depends on converter clock phase
  assign take_pwr = start_conv_in && !busy_out && burst_mode_on_in && !converter_on_in
    && !track_mode_sel_in;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pwr_q <= PWR_TIME_RST[3:0];
    end else if (sfr_req_in.wr && hit(PAGE_CFG, ADDR_PWR_TIME)) begin
      pwr_q <= sfr_req_in.wdata[3:0];
    end
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_q <= 1'b0;
      cnt_q <= 9'h000;
    end else if (take_pwr) begin
      wait_q <= 1'b1;
      cnt_q <= 9'h001;
    end else if (conv_start_out) begin
      wait_q <= 1'b0;
    end else if (wait_q) begin
      cnt_q <= cnt_q + 9'h001;
    end
  end
  sequence idle_start_s;
    start_conv_in && !busy_out && converter_on_in;
  endsequence
  sequence quiet_s;
    !conv_start_out [*3];
  endsequence
  rd_answer_a: assert property (sfr_req_in.rd |=> sfr_rvalid_out)
    else $error("read not answered one cycle later");
  // Mode outputs sit one flop behind the register bit, so they follow two cycles on
  twelve_mirror_a: assert property (sfr_req_in.wr && hit(PAGE_MAIN, ADDR_ACC_CFG)
    |-> ##2 twelve_bit_mode_on_out == $past(sfr_req_in.wdata[7], 2))
    else $error("twelve bit mode does not follow write");
  low_power_mirror_a: assert property (sfr_req_in.wr && hit(PAGE_CFG, ADDR_PWR_TIME)
    |-> ##2 low_power_on_out == $past(sfr_req_in.wdata[7], 2))
    else $error("low power mode does not follow write");
  accum_reads_zero_a: assert property (sfr_req_in.rd && hit(PAGE_MAIN, ADDR_ACC_CFG)
    |=> sfr_rvalid_out && !sfr_rdata_out[6])
    else $error("accumulate bit read back nonzero");
  pwr_unused_zero_a: assert property (sfr_req_in.rd && hit(PAGE_CFG, ADDR_PWR_TIME)
    |=> sfr_rdata_out[6:4] == 3'h0)
    else $error("unused power-up bits read nonzero");
  track_rsvd_zero_a: assert property (sfr_req_in.rd && hit(PAGE_CFG, ADDR_TRACK_TIME)
    |=> sfr_rdata_out[7:6] == 2'h0)
    else $error("reserved track bits read nonzero");
  plain_power_a: assert property (!$past(reset_in) && $past(!burst_mode_on_in)
    |-> powered_out == $past(converter_on_in))
    else $error("power does not follow converter enable");
  burst_stay_on_a: assert property (!$past(reset_in)
    && $past(burst_mode_on_in && converter_on_in) |-> powered_out)
    else $error("converter dropped power in enabled burst");
  normal_start_a: assert property (idle_start_s ##0 !track_mode_sel_in
    |=> conv_start_out)
    else $error("normal track start not immediate");
  delayed_start_a: assert property (idle_start_s ##0 track_mode_sel_in |=> quiet_s)
    else $error("delayed track start too early");
  pwr_wait_a: assert property (wait_q
    |-> conv_start_out == (cnt_q == ({5'h00, pwr_q} + 9'h001) * 9'h010 + 9'h002))
    else $error("power-up delay length wrong");
endmodule
bind adc_burst_ctrl adc_burst_ctrl_chk i_adc_burst_ctrl_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .sfr_req_in(sfr_req_in),
  .sfr_rdata_out(sfr_rdata_out), .sfr_rvalid_out(sfr_rvalid_out),
  .burst_mode_on_in(burst_mode_on_in), .converter_on_in(converter_on_in),
  .track_mode_sel_in(track_mode_sel_in), .start_conv_in(start_conv_in),
  .conv_start_out(conv_start_out), .powered_out(powered_out),
  .low_power_on_out(low_power_on_out), .twelve_bit_mode_on_out(twelve_bit_mode_on_out),
  .busy_out(busy_out));
`default_nettype wire

/* File: testbench/adc_burst_ctrl_test.sv */
// Self-checking testbench for the burst accumulator control block
`timescale 1ns/10ps
`default_nettype none
module adc_burst_ctrl_test;
  import adc_burst_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  sfr_req_s req = '0;
  conv_result_s res = '0;
  logic burst = 1'b0;
  logic conv_on = 1'b0;
  logic tm = 1'b0;
  logic start = 1'b0;
  logic sar = 1'b0;
  logic [1:0] sar_cnt = 2'h0;
  logic [7:0] rdata;
  logic [7:0] rd_q;
  logic [15:0] acc;
  logic rvalid, cstart, powered, lowp, twelve, busy;
  int num_errors = 0;
  int total_checks = 0;
  int cnt;
  int n;
  adc_burst_ctrl i_adc_burst_ctrl (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .sfr_req_in(req), .sfr_rdata_out(rdata), .sfr_rvalid_out(rvalid),
    .burst_mode_on_in(burst), .converter_on_in(conv_on), .track_mode_sel_in(tm),
    .start_conv_in(start), .sar_clk_en_in(sar), .conv_result_in(res),
    .conv_start_out(cstart), .powered_out(powered), .low_power_on_out(lowp),
    .twelve_bit_mode_on_out(twelve), .busy_out(busy));
  always #12.5 core_clk_in = ~core_clk_in;
  // Converter clock enable runs free at a quarter of the core rate
  always @(posedge core_clk_in) begin
    sar_cnt <= sar_cnt + 2'h1;
    sar <= #1 (sar_cnt == 2'h3);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge core_clk_in);
    #1;
  endtask
  // An idle cycle between accesses keeps every strobe a clean single pulse
  task automatic sfr(input logic [7:0] pg, input logic [7:0] ad, input logic w,
      input logic [7:0] wd);
    req = '{pg, ad, w, !w, wd};
    step();
    rd_q = rvalid ? rdata : 8'hxx;
    req = '0;
    step();
  endtask
  task automatic rdchk(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp);
    sfr(pg, ad, 1'b0, 8'h00);
    chk({8'h00, rd_q}, {8'h00, exp});
    // Read data falls back to zero once its answer cycle is over
    chk({8'h00, rdata}, 16'h0000);
  endtask
  task automatic res_chk(input logic [15:0] exp);
    sfr(PAGE_MAIN, ADDR_RES_HIGH, 1'b0, 8'h00);
    acc[15:8] = rd_q;
    sfr(PAGE_MAIN, ADDR_RES_LOW, 1'b0, 8'h00);
    acc[7:0] = rd_q;
    chk(acc, exp);
  endtask
  task automatic wait_start(output int c);
    c = 0;
    while (cstart !== 1'b1 && c < 600) begin
      step();
      start = 1'b0;
      res = '0;
      c++;
    end
  endtask
  // Plays the analog core: one result in the cycle after each conversion start pulse
  task automatic run(input logic [11:0] d, input int num, input int first, input int gap);
    start = 1'b1;
    wait_start(cnt);
    if (first >= 0) chk(16'(cnt), 16'(first));
    for (int i = 0; i < num; i++) begin
      step();
      res = '{1'b1, d};
      if (i < num - 1) begin
        wait_start(cnt);
        chk(16'(cnt), 16'(gap));
      end
    end
    step();
    res = '0;
    chk({15'h0, busy}, 16'h0000);
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    #1;
    reset_in = 1'b0;
    rdchk(PAGE_MAIN, ADDR_ACC_CFG, 8'h00);
    rdchk(PAGE_CFG, ADDR_PWR_TIME, 8'h0f);
    rdchk(PAGE_CFG, ADDR_TRACK_TIME, 8'h1e);
    rdchk(PAGE_MAIN, 8'h10, 8'h00);
    sfr(PAGE_MAIN, ADDR_ACC_CFG, 1'b1, 8'hf8);
    rdchk(PAGE_MAIN, ADDR_ACC_CFG, 8'hb8);
    chk({15'h0, twelve}, 16'h0001);
    sfr(PAGE_CFG, ADDR_PWR_TIME, 1'b1, 8'hf0);
    rdchk(PAGE_CFG, ADDR_PWR_TIME, 8'h80);
    chk({15'h0, lowp}, 16'h0001);
    sfr(PAGE_CFG, ADDR_TRACK_TIME, 1'b1, 8'h3f);
    rdchk(PAGE_CFG, ADDR_TRACK_TIME, 8'h3f);
    sfr(PAGE_MAIN, ADDR_ACC_CFG, 1'b1, 8'h00);
    chk({15'h0, twelve}, 16'h0000);
    conv_on = 1'b1;
    step();
    chk({15'h0, powered}, 16'h0001);
    run(12'h123, 1, 1, 0);
    res_chk(16'h0123);
    run(12'h010, 1, 1, 0);
    res_chk(16'h0010);
    sfr(PAGE_MAIN, ADDR_ACC_CFG, 1'b1, 8'h40);
    run(12'h005, 1, 1, 0);
    res_chk(16'h0015);
    sfr(PAGE_MAIN, ADDR_RES_HIGH, 1'b1, 8'h00);
    sfr(PAGE_MAIN, ADDR_RES_LOW, 1'b1, 8'h00);
    res_chk(16'h0000);
    tm = 1'b1;
    run(12'h001, 1, -1, 0);
    chk(16'(cnt >= 9 && cnt <= 15), 16'h0001);
    tm = 1'b0;
    conv_on = 1'b0;
    step();
    chk({15'h0, powered}, 16'h0000);
    sfr(PAGE_MAIN, ADDR_RES_HIGH, 1'b1, 8'h0a);
    sfr(PAGE_MAIN, ADDR_RES_LOW, 1'b1, 8'hbc);
    for (int k = 0; k < 10; k++) begin
      sfr(PAGE_MAIN, ADDR_ACC_CFG, 1'b1, 8'((k / 5) * 128 + (k % 5) * 8));
      res_chk(k % 5 < 4 ? 16'h0abc >> (k % 5) : (k >= 5 ? 16'habc0 : 16'haf00));
    end
    burst = 1'b1;
    conv_on = 1'b1;
    for (int k = 0; k < 6; k++) begin
      n = (k == 0) ? 1 : 2 << k;
      sfr(PAGE_MAIN, ADDR_ACC_CFG, 1'b1, 8'(k));
      run(12'h0ff, n, 1, 4);
      res_chk(16'(n * 255));
      chk({15'h0, powered}, 16'h0001);
    end
    sfr(PAGE_CFG, ADDR_TRACK_TIME, 1'b1, 8'h1e);
    sfr(PAGE_MAIN, ADDR_ACC_CFG, 1'b1, 8'h01);
    run(12'h0ff, 4, 1, (64 - 30) * 2 + 2);
    conv_on = 1'b0;
    sfr(PAGE_MAIN, ADDR_ACC_CFG, 1'b1, 8'h00);
    sfr(PAGE_CFG, ADDR_PWR_TIME, 1'b1, 8'h01);
    run(12'h0ff, 1, (1 + 1) * 16 + 2, 0);
    step();
    step();
    chk({15'h0, powered}, 16'h0000);
    chk({15'h0, lowp}, 16'h0000);
    sfr(PAGE_CFG, ADDR_PWR_TIME, 1'b1, 8'h04);
    run(12'h0ff, 1, (4 + 1) * 16 + 2, 0);
    end_sim();
  end
  initial begin
    #500000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
